// >>> rtl/pmf_consts.svh
// Purpose: offsets, field positions, reset values of the ptp message filter
// Assumes: byte addresses on a 32-bit ahb-lite bus, one word per register
// Notes: included by the filter top and its package users
// Behaviour
// - delay response paired with delay request, forwarded
// - peer delay responses paired with peer request
// - drop sync, follow-up, delay request without master
// - domain check forwards match, drops mismatch
// - checksum enable regenerates, disabled writes zero
// - zero ipv4 checksum kept, ipv6 updated whenever modified
// - four-bit version resets two, captures on match
// - version mismatch packets dropped
// - eight-bit domain resets zero, gates capture
// - window accesses go to selected units
// - one-bit stamp unit selector at bit eight
// - two-bit fire unit selector, three reserved
// - filtering active only with ptp mode enabled
`ifndef PMF_CONSTS_SVH
`define PMF_CONSTS_SVH
`define PMF_OFF_MODE 16'h0510
`define PMF_OFF_CFG2 16'h0514
`define PMF_OFF_DOMVER 16'h0518
`define PMF_OFF_UNIT 16'h0520
`define PMF_WIN_LO 16'h052c
`define PMF_WIN_HI 16'h05b3
`define PMF_CFG2_DLY 8
`define PMF_CFG2_PDLY 7
`define PMF_CFG2_AUTO 5
`define PMF_CFG2_DOM 4
`define PMF_CFG2_CKS 2
`define PMF_CFG2_RST 9'h004
`define PMF_VER_RST 4'h2
`define PMF_DOM_RST 8'h00
`define PMF_STAMP_BIT 8
`define PMF_FIRE_RSVD 2'h3
`endif

// >>> rtl/pmf_pkg.sv
// Purpose: types shared by the ptp message filter
// Assumes: message type codes as carried in the ptp header
// Notes: none
package pmf_pkg;
  typedef enum logic [3:0] {
    PMF_SYNC = 4'h0,
    PMF_DREQ = 4'h1,
    PMF_PREQ = 4'h2,
    PMF_PRESP = 4'h3,
    PMF_FUP = 4'h8,
    PMF_DRESP = 4'h9,
    PMF_PRFUP = 4'ha
  } pmf_msg_e;
  typedef enum logic [1:0] {
    PMF_ST_IDLE = 2'b01,
    PMF_ST_WAIT = 2'b10
  } pmf_bus_e;
  typedef struct packed {
    logic [7:0] dom;
    logic [15:0] seq;
    logic [79:0] src;
  } pmf_id_s;
endpackage

// >>> rtl/pmf_top.sv
// Purpose: ptp message filter configuration registers and filter decisions
// Assumes: message fields arrive on hclk from the frame parser, one per pulse
// Notes: window reads add one wait state; register reads are zero wait
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "pmf_consts.svh"
module pmf_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [15:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic stamp_unit_selector,
  output logic [1:0] fire_unit_selector,
  output logic ptp_clk_en,
  output logic win_rd,
  output logic win_wr,
  output logic [15:0] win_addr,
  output logic [31:0] win_wdata,
  input wire logic [31:0] win_rdata,
  input wire logic msg_valid,
  input wire pmf_pkg::pmf_msg_e msg_type,
  input wire logic [3:0] msg_version,
  input wire pmf_pkg::pmf_id_s msg_id,
  input wire logic bmc_known,
  input wire logic msg_ipv6,
  input wire logic msg_modified,
  input wire logic [15:0] cksum_in,
  input wire logic [15:0] cksum_calc,
  output logic res_valid,
  output logic fwd_host,
  output logic drop,
  output logic capture,
  output logic [15:0] cksum_out
);
  import pmf_pkg::*;

  logic mode_q;
  logic [8:0] cfg2_q;
  logic [3:0] ver_q;
  logic [7:0] configured_time_domain;
  logic stamp_q;
  logic [1:0] fire_q;
  pmf_bus_e st_q;
  logic dph_wr_q;
  logic [15:0] dph_addr_q;
  logic [31:0] hrdata_q;
  logic win_rd_q;
  logic [15:0] win_addr_q;
  logic aph;
  logic aph_win;
  logic [31:0] rd_val;
  logic wr_mode;
  logic wr_cfg2;
  logic wr_domver;
  logic wr_unit;
  pmf_id_s dly_q;
  pmf_id_s pdly_q;
  logic dly_v_q;
  logic pdly_v_q;

  function automatic logic in_win(input logic [15:0] a);
    in_win = (a >= `PMF_WIN_LO) && (a <= `PMF_WIN_HI);
  endfunction

  function automatic logic id_eq(input pmf_id_s a, input pmf_id_s b);
    id_eq = (a.dom == b.dom) && (a.seq == b.seq) && (a.src == b.src);
  endfunction

  // bus address phase
  assign aph = hsel && htrans[1] && hready;
  assign aph_win = aph && in_win(haddr);

  always_comb
  begin
    rd_val = 32'h0000_0000;
    if (haddr == `PMF_OFF_MODE)
      rd_val = {29'h0000_0000, pdly_v_q, dly_v_q, mode_q};
    else if (haddr == `PMF_OFF_CFG2)
      rd_val = {23'h00_0000, cfg2_q};
    else if (haddr == `PMF_OFF_DOMVER)
      rd_val = {20'h0_0000, ver_q, configured_time_domain};
    else if (haddr == `PMF_OFF_UNIT)
      rd_val = {23'h00_0000, stamp_q, 6'h00, fire_q};
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dph_wr_q <= 1'b0;
      dph_addr_q <= 16'h0000;
    end
    else if (hready)
    begin
      dph_wr_q <= aph && hwrite;
      dph_addr_q <= haddr;
    end
  end

  // window reads wait one cycle so the selected unit can answer
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_q <= PMF_ST_IDLE;
      win_rd_q <= 1'b0;
      win_addr_q <= 16'h0000;
      hrdata_q <= 32'h0000_0000;
    end
    else
    begin
      case (st_q)
        PMF_ST_IDLE:
        begin
          win_rd_q <= aph_win && !hwrite;
          win_addr_q <= haddr;
          if (aph_win && !hwrite)
            st_q <= PMF_ST_WAIT;
          else if (aph && !hwrite)
            hrdata_q <= rd_val;
        end
        PMF_ST_WAIT:
        begin
          win_rd_q <= 1'b0;
          hrdata_q <= win_rdata;
          st_q <= PMF_ST_IDLE;
        end
        default:
          st_q <= PMF_ST_IDLE;
      endcase
    end
  end

  assign hreadyout = (st_q == PMF_ST_IDLE);
  assign hrdata = hrdata_q;
  assign hresp = 1'b0;
  assign win_rd = win_rd_q;
  assign win_wr = dph_wr_q && in_win(dph_addr_q);
  assign win_addr = win_wr ? dph_addr_q : win_addr_q;
  assign win_wdata = hwdata;
  assign wr_mode = dph_wr_q && (dph_addr_q == `PMF_OFF_MODE);
  assign wr_cfg2 = dph_wr_q && (dph_addr_q == `PMF_OFF_CFG2);
  assign wr_domver = dph_wr_q && (dph_addr_q == `PMF_OFF_DOMVER);
  assign wr_unit = dph_wr_q && (dph_addr_q == `PMF_OFF_UNIT);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mode_q <= 1'b0;
      cfg2_q <= `PMF_CFG2_RST;
    end
    else
    begin
      if (wr_mode)
        mode_q <= hwdata[0];
      if (wr_cfg2)
        cfg2_q <= hwdata[8:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ver_q <= `PMF_VER_RST;
      configured_time_domain <= `PMF_DOM_RST;
    end
    else if (wr_domver)
    begin
      ver_q <= hwdata[11:8];
      configured_time_domain <= hwdata[7:0];
    end
  end

  // reserved fire code is refused so the selector never points nowhere
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      stamp_q <= 1'b0;
      fire_q <= 2'h0;
    end
    else if (wr_unit)
    begin
      stamp_q <= hwdata[`PMF_STAMP_BIT];
      if (hwdata[1:0] != `PMF_FIRE_RSVD)
        fire_q <= hwdata[1:0];
    end
  end

  assign stamp_unit_selector = stamp_q;
  assign fire_unit_selector = fire_q;
  assign ptp_clk_en = mode_q;
  // filter decision
  logic ver_ok;
  logic dom_ok;
  logic auto_hit;
  logic dly_resp;
  logic pd_resp;
  logic dly_hit;
  logic pd_hit;
  logic drop_d;
  logic fwd_d;
  logic [15:0] cks_d;
  logic res_valid_q;
  logic fwd_q;
  logic drop_q;
  logic cap_q;
  logic [15:0] cks_q;

  assign ver_ok = (msg_version == ver_q);
  assign dom_ok = !cfg2_q[`PMF_CFG2_DOM] || (msg_id.dom == configured_time_domain);
  assign auto_hit = cfg2_q[`PMF_CFG2_AUTO] && !bmc_known &&
    (msg_type == PMF_SYNC || msg_type == PMF_FUP || msg_type == PMF_DREQ);
  assign dly_resp = cfg2_q[`PMF_CFG2_DLY] && (msg_type == PMF_DRESP);
  assign pd_resp = cfg2_q[`PMF_CFG2_PDLY] && (msg_type == PMF_PRESP || msg_type == PMF_PRFUP);
  assign dly_hit = dly_v_q && id_eq(dly_q, msg_id);
  assign pd_hit = pdly_v_q && id_eq(pdly_q, msg_id);
  assign drop_d = mode_q && (!ver_ok || !dom_ok || auto_hit ||
    (dly_resp && !dly_hit) || (pd_resp && !pd_hit));
  assign fwd_d = mode_q && !drop_d && (cfg2_q[`PMF_CFG2_DOM] || dly_resp || pd_resp);

  // a zero ipv4 checksum means the sender opted out, so keep it
  always_comb
  begin
    cks_d = cksum_in;
    if (mode_q && msg_modified)
    begin
      if (msg_ipv6)
        cks_d = cksum_calc;
      else if (cksum_in == 16'h0000)
        cks_d = 16'h0000;
      else if (cfg2_q[`PMF_CFG2_CKS])
        cks_d = cksum_calc;
      else
        cks_d = 16'h0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      res_valid_q <= 1'b0;
      fwd_q <= 1'b0;
      drop_q <= 1'b0;
      cap_q <= 1'b0;
      cks_q <= 16'h0000;
    end
    else
    begin
      res_valid_q <= msg_valid;
      if (msg_valid)
      begin
        fwd_q <= fwd_d;
        drop_q <= drop_d;
        cap_q <= mode_q && ver_ok && dom_ok && !drop_d;
        cks_q <= cks_d;
      end
    end
  end

  assign res_valid = res_valid_q;
  assign fwd_host = fwd_q;
  assign drop = drop_q;
  assign capture = cap_q;
  assign cksum_out = cks_q;
  // a newer request supersedes the held one
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dly_v_q <= 1'b0;
      pdly_v_q <= 1'b0;
      dly_q <= '0;
      pdly_q <= '0;
    end
    else if (msg_valid && mode_q && !drop_d)
    begin
      if (msg_type == PMF_DREQ)
      begin
        dly_v_q <= 1'b1;
        dly_q <= msg_id;
      end
      else if (dly_resp && dly_hit)
        dly_v_q <= 1'b0;
      if (msg_type == PMF_PREQ)
      begin
        pdly_v_q <= 1'b1;
        pdly_q <= msg_id;
      end
      else if (cfg2_q[`PMF_CFG2_PDLY] && msg_type == PMF_PRFUP && pd_hit)
        pdly_v_q <= 1'b0;
    end
  end

  chk_delay_pair: assert property (@(posedge hclk) disable iff (!hresetn)
    msg_valid && mode_q && dly_resp && dly_hit && ver_ok && dom_ok && !auto_hit
    |=> fwd_host && !drop)
    else $error("matched delay response not forwarded");
  chk_pdelay_miss: assert property (@(posedge hclk) disable iff (!hresetn)
    msg_valid && mode_q && pd_resp && !pd_hit |=> drop && !fwd_host)
    else $error("unmatched peer delay response kept");
  chk_auto_drop: assert property (@(posedge hclk) disable iff (!hresetn)
    msg_valid && mode_q && auto_hit |=> res_valid && drop && !capture)
    else $error("message kept before master known");
  chk_domain_drop: assert property (@(posedge hclk) disable iff (!hresetn)
    msg_valid && mode_q && cfg2_q[`PMF_CFG2_DOM] && msg_id.dom != configured_time_domain
    |=> drop && !fwd_host)
    else $error("foreign domain not dropped");
  chk_cksum_off: assert property (@(posedge hclk) disable iff (!hresetn)
    msg_valid && mode_q && msg_modified && !msg_ipv6 && !cfg2_q[`PMF_CFG2_CKS]
    |=> cksum_out == 16'h0000)
    else $error("checksum not zeroed when disabled");
  chk_cksum_v6: assert property (@(posedge hclk) disable iff (!hresetn)
    msg_valid && mode_q && msg_modified && msg_ipv6 |=> cksum_out == $past(cksum_calc))
    else $error("ipv6 checksum not updated");
  chk_version_drop: assert property (@(posedge hclk) disable iff (!hresetn)
    msg_valid && mode_q && msg_version != ver_q |=> drop && !capture)
    else $error("wrong version not dropped");
  chk_mode_off: assert property (@(posedge hclk) disable iff (!hresetn)
    msg_valid && !mode_q |=> !drop && !fwd_host && !capture)
    else $error("filter acted with ptp mode off");
  chk_fire_rsvd: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_unit && hwdata[1:0] == `PMF_FIRE_RSVD |=> $stable(fire_unit_selector))
    else $error("reserved fire selector stored");
  chk_win_read: assert property (@(posedge hclk) disable iff (!hresetn)
    win_rd |-> !hreadyout ##1 hreadyout && hrdata == $past(win_rdata))
    else $error("window read data lost");
endmodule

// >>> verif/pmf_tb.sv
// Purpose: self-checking bench for the ptp message filter registers and decisions
// Assumes: hready looped back from hreadyout, one slave, whole-word transfers
// Notes: cksum_calc held at a fixed value so regenerated sums are recognisable
`timescale 1ns/100ps
`include "pmf_consts.svh"
module testbench;
  import pmf_pkg::*;
  logic hclk, hresetn, hsel, hwrite, msg_valid, bmc_known, msg_ipv6, msg_modified;
  logic [15:0] haddr, cksum_in, cksum_calc, win_addr, cksum_out;
  logic [1:0] htrans, fire_unit_selector;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, win_rdata, win_wdata, rd;
  logic hreadyout, hresp, stamp_unit_selector, ptp_clk_en, win_rd, win_wr;
  logic res_valid, fwd_host, drop, capture;
  pmf_msg_e msg_type;
  pmf_msg_e ad[3] = '{PMF_SYNC, PMF_FUP, PMF_DREQ};
  logic [3:0] msg_version;
  pmf_id_s msg_id;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [15:0] wr_addr_seen = 16'h0000;
  logic [31:0] wr_data_seen = 32'h0000_0000;
  logic [16:0] rd_addr_seen = 17'h0_0000;

  pmf_top pmf_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .stamp_unit_selector(stamp_unit_selector), .fire_unit_selector(fire_unit_selector),
    .ptp_clk_en(ptp_clk_en), .win_rd(win_rd), .win_wr(win_wr), .win_addr(win_addr),
    .win_wdata(win_wdata), .win_rdata(win_rdata), .msg_valid(msg_valid),
    .msg_type(msg_type), .msg_version(msg_version), .msg_id(msg_id),
    .bmc_known(bmc_known), .msg_ipv6(msg_ipv6), .msg_modified(msg_modified),
    .cksum_in(cksum_in), .cksum_calc(cksum_calc), .res_valid(res_valid),
    .fwd_host(fwd_host), .drop(drop), .capture(capture), .cksum_out(cksum_out));

  initial
  begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // a hang in a handshake wait ends here
  always @(posedge hclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      fails++;
      tally_and_finish();
    end
  end

  // window strobes are caught while they stand, checked later
  always @(posedge hclk)
  begin
    if (win_rd === 1'b1)
      rd_addr_seen <= {hreadyout, win_addr};
    if (win_wr === 1'b1)
    begin
      wr_addr_seen <= win_addr;
      wr_data_seen <= win_wdata;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one single transfer; hready sampled at each edge, read data taken with it
  task automatic bus(input logic [15:0] a, input logic w, input logic [31:0] d);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic rdchk(input logic [15:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(rd, e);
  endtask

  // e is {fwd_host, drop, capture}; results stand from the edge after msg_valid
  task automatic msg(input pmf_msg_e t, input logic [3:0] v, input logic [7:0] d,
      input logic [15:0] s, input logic b, input logic v6, input logic m,
      input logic [15:0] ci, input logic [2:0] e, input logic [15:0] ec);
    msg_valid <= 1'b1;
    msg_type <= t;
    msg_version <= v;
    msg_id <= '{dom: d, seq: s, src: 80'h0a0b0c0d0e0f10111213};
    bmc_known <= b;
    msg_ipv6 <= v6;
    msg_modified <= m;
    cksum_in <= ci;
    @(posedge hclk);
    msg_valid <= 1'b0;
    #1;
    chk({res_valid, fwd_host, drop, capture}, {1'b1, e});
    chk(cksum_out, ec);
    @(posedge hclk);
  endtask

  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b1;
    hsize = 3'h2;
    haddr = 16'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    win_rdata = 32'h5a5a0001;
    msg_valid = 1'b0;
    msg_type = PMF_SYNC;
    msg_version = 4'h0;
    msg_id = '0;
    bmc_known = 1'b0;
    msg_ipv6 = 1'b0;
    msg_modified = 1'b0;
    cksum_in = 16'h0;
    cksum_calc = 16'h2222;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk(`PMF_OFF_MODE, 32'h0);
    rdchk(`PMF_OFF_CFG2, 32'h4);
    rdchk(`PMF_OFF_DOMVER, 32'h200);
    rdchk(`PMF_OFF_UNIT, 32'h0);
    bus(`PMF_OFF_UNIT, 1'b1, 32'h102);
    rdchk(`PMF_OFF_UNIT, 32'h102);
    chk({stamp_unit_selector, fire_unit_selector}, 3'b110);
    // reserved fire code keeps the old unit, reserved bits stay zero
    bus(`PMF_OFF_UNIT, 1'b1, 32'hffffffff);
    rdchk(`PMF_OFF_UNIT, 32'h102);
    bus(`PMF_OFF_DOMVER, 1'b1, 32'hffffffff);
    rdchk(`PMF_OFF_DOMVER, 32'h0fff);
    bus(`PMF_OFF_DOMVER, 1'b1, 32'h200);
    bus(16'h0600, 1'b1, 32'hffffffff);
    rdchk(16'h0600, 32'h0);
    chk(hresp, 1'b0);
    chk(wr_addr_seen, 16'h0000);
    bus(16'h0540, 1'b1, 32'h1234abcd);
    rdchk(16'h0530, 32'h5a5a0001);
    chk(win_addr, 16'h0530);
    chk(rd_addr_seen, {1'b0, 16'h0530});
    chk(wr_addr_seen, 16'h0540);
    chk(wr_data_seen, 32'h1234abcd);
    msg(PMF_SYNC, 4'h3, 8'h0, 16'h1, 1'b0, 1'b0, 1'b1, 16'h1111, 3'b000, 16'h1111);
    bus(`PMF_OFF_MODE, 1'b1, 32'h1);
    @(posedge hclk);
    chk(ptp_clk_en, 1'b1);
    msg(PMF_SYNC, 4'h3, 8'h0, 16'h1, 1'b1, 1'b0, 1'b0, 16'h1, 3'b010, 16'h1);
    msg(PMF_SYNC, 4'h2, 8'h0, 16'h1, 1'b1, 1'b0, 1'b0, 16'h1, 3'b001, 16'h1);
    bus(`PMF_OFF_DOMVER, 1'b1, 32'h205);
    msg(PMF_SYNC, 4'h2, 8'h9, 16'h1, 1'b1, 1'b0, 1'b0, 16'h1, 3'b001, 16'h1);
    bus(`PMF_OFF_CFG2, 1'b1, 32'h14);
    msg(PMF_SYNC, 4'h2, 8'h5, 16'h1, 1'b1, 1'b0, 1'b0, 16'h1, 3'b101, 16'h1);
    msg(PMF_SYNC, 4'h2, 8'h6, 16'h1, 1'b1, 1'b0, 1'b0, 16'h1, 3'b010, 16'h1);
    bus(`PMF_OFF_DOMVER, 1'b1, 32'h200);
    bus(`PMF_OFF_CFG2, 1'b1, 32'h24);
    foreach (ad[i])
      msg(ad[i], 4'h2, 8'h0, 16'h1, 1'b0, 1'b0, 1'b0, 16'h1, 3'b010, 16'h1);
    msg(PMF_SYNC, 4'h2, 8'h0, 16'h1, 1'b1, 1'b0, 1'b0, 16'h1, 3'b001, 16'h1);
    bus(`PMF_OFF_CFG2, 1'b1, 32'h104);
    msg(PMF_DREQ, 4'h2, 8'h0, 16'h7, 1'b1, 1'b0, 1'b0, 16'h1, 3'b001, 16'h1);
    msg(PMF_DRESP, 4'h2, 8'h0, 16'h8, 1'b1, 1'b0, 1'b0, 16'h1, 3'b010, 16'h1);
    msg(PMF_DRESP, 4'h2, 8'h0, 16'h7, 1'b1, 1'b0, 1'b0, 16'h1, 3'b101, 16'h1);
    msg(PMF_DRESP, 4'h2, 8'h0, 16'h7, 1'b1, 1'b0, 1'b0, 16'h1, 3'b010, 16'h1);
    bus(`PMF_OFF_CFG2, 1'b1, 32'h84);
    msg(PMF_PREQ, 4'h2, 8'h0, 16'h9, 1'b1, 1'b0, 1'b0, 16'h1, 3'b001, 16'h1);
    msg(PMF_PRESP, 4'h2, 8'h0, 16'h9, 1'b1, 1'b0, 1'b0, 16'h1, 3'b101, 16'h1);
    msg(PMF_PRFUP, 4'h2, 8'h0, 16'h9, 1'b1, 1'b0, 1'b0, 16'h1, 3'b101, 16'h1);
    msg(PMF_PRFUP, 4'h2, 8'h0, 16'h9, 1'b1, 1'b0, 1'b0, 16'h1, 3'b010, 16'h1);
    bus(`PMF_OFF_CFG2, 1'b1, 32'h4);
    msg(PMF_SYNC, 4'h2, 8'h0, 16'h1, 1'b1, 1'b0, 1'b1, 16'h1111, 3'b001, 16'h2222);
    msg(PMF_SYNC, 4'h2, 8'h0, 16'h1, 1'b1, 1'b0, 1'b1, 16'h0, 3'b001, 16'h0);
    msg(PMF_SYNC, 4'h2, 8'h0, 16'h1, 1'b1, 1'b0, 1'b0, 16'h1111, 3'b001, 16'h1111);
    bus(`PMF_OFF_CFG2, 1'b1, 32'h0);
    msg(PMF_SYNC, 4'h2, 8'h0, 16'h1, 1'b1, 1'b0, 1'b1, 16'h1111, 3'b001, 16'h0);
    msg(PMF_SYNC, 4'h2, 8'h0, 16'h1, 1'b1, 1'b1, 1'b1, 16'h1111, 3'b001, 16'h2222);
    tally_and_finish();
  end
endmodule
